// file: core/sensor_fault_status_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_consts.vh"
module sensor_fault_status_flags #(
   parameter ADDR_W = 16
) (
   input wire ref_clk,
   input wire rst_n,
   input wire measDone,
   input wire measOk,
   input wire measTimeout,
   input wire badSample,
   input wire brownoutReset,
   input wire resetCmd,
   input wire faultClearWrite,
   input wire heaterMeasFail,
   input wire heaterCfgBad,
   input wire outputCfgBad,
   input wire heaterTempOutOfRange,
   input wire scaleFactorValid,
   input wire [ADDR_W-1:0] readAddr,
   output reg [15:0] readData,
   output wire selfDiagFlag,
   output reg [15:0] fault_flags
);
   // ==========================================
   // Constants
   localparam STICKY_N = 4;
   localparam LIVE_N = 4;
   localparam [15:0] RESET_WORD = `FAULT_FLAGS_RESET;
   localparam [15:0] STATUS_ADDR = `FAULT_FLAGS_ADDR;
   localparam [STICKY_N-1:0] STICKY_RESET = {
      RESET_WORD[`BIT_BAD_SAMPLE],
      RESET_WORD[`BIT_MEAS_TIMEOUT],
      RESET_WORD[`BIT_LOW_VREG],
      RESET_WORD[`BIT_NO_MEAS]
   };
   localparam [LIVE_N-1:0] LIVE_RESET = {
      RESET_WORD[`BIT_TEMP_RANGE],
      RESET_WORD[`BIT_OUTPUT_CFG],
      RESET_WORD[`BIT_HEATER_CFG],
      RESET_WORD[`BIT_HEATER_MEAS]
   };
   localparam [0:0] SCALE_RESET = RESET_WORD[`BIT_SCALE_ERR];

   // ==========================================
   // Event flags
   wire [STICKY_N-1:0] stickySet;
   wire [STICKY_N-1:0] stickyClr;
   wire [STICKY_N-1:0] stickyQ;
   wire goodMeas;
   wire noMeas;
   wire lowVreg;
   wire timeoutFlag;
   wire badSampleFlag;

   // ==========================================
   // Scale factor state
   reg scaleErr_q;
   reg scaleErr_d;
   reg pendingValid_q;
   wire scaleClear;

   // ==========================================
   // Live indications and read port
   wire [LIVE_N-1:0] liveIn;
   wire [LIVE_N-1:0] liveFlags;
   wire addrHit;
   reg [15:0] readData_d;

   // ==========================================
   // Set and clear sources
   // Good measurement clears
   assign goodMeas = measDone & measOk;

   assign stickySet[0] = 1'b0;
   assign stickyClr[0] = measDone;

   assign stickySet[1] = brownoutReset;
   assign stickyClr[1] = resetCmd | faultClearWrite;

   assign stickySet[2] = measTimeout;
   assign stickyClr[2] = goodMeas;

   assign stickySet[3] = badSample;
   assign stickyClr[3] = goodMeas;

   // ==========================================
   // Sticky flag bank
   // Set wins, so an event in a clearing cycle survives
   genvar s;
   generate
      for (s = 0; s < STICKY_N; s = s + 1) begin : gSticky
         sticky_flag #(
            .RESET_VAL(STICKY_RESET[s])
         ) uFlag (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .setEvt(stickySet[s]),
            .clrEvt(stickyClr[s]),
            .flag_q(stickyQ[s])
         );
      end
   endgenerate

   assign noMeas = stickyQ[0];
   assign lowVreg = stickyQ[1];
   assign timeoutFlag = stickyQ[2];
   assign badSampleFlag = stickyQ[3];

   // ==========================================
   // Scale factor
   // Valid before reset
   assign scaleClear = resetCmd & pendingValid_q & scaleFactorValid;

   always @* begin
      scaleErr_d = scaleErr_q;
      if (!scaleFactorValid) begin
         scaleErr_d = 1'b1;
      end else if (scaleClear) begin
         scaleErr_d = 1'b0;
      end
   end

   // Power cycle clears too; a still bad factor sets again
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         scaleErr_q <= SCALE_RESET;
         pendingValid_q <= 1'b0;
      end else begin
         scaleErr_q <= scaleErr_d;
         pendingValid_q <= scaleFactorValid;
      end
   end

   // ==========================================
   // Live indications
   // Heater measurement, heater config, output config and temperature range faults
   assign liveIn = {heaterTempOutOfRange, outputCfgBad, heaterCfgBad, heaterMeasFail};

   genvar l;
   generate
      for (l = 0; l < LIVE_N; l = l + 1) begin : gLive
         reg live_q;
         always @(posedge ref_clk) begin
            if (!rst_n) begin
               live_q <= LIVE_RESET[l];
            end else begin
               live_q <= liveIn[l];
            end
         end
         assign liveFlags[l] = live_q;
      end
   endgenerate

   // ==========================================
   // Self-diagnostics
   // Follows either cause
   assign selfDiagFlag = timeoutFlag | badSampleFlag;

   // ==========================================
   // Status word
   // Unused bits 0-3, 5 and 6 read as zero
   always @* begin
      fault_flags = 16'h0000;
      fault_flags[`BIT_SELF_DIAG] = selfDiagFlag;
      fault_flags[`BIT_NO_MEAS] = noMeas;
      fault_flags[`BIT_LOW_VREG] = lowVreg;
      fault_flags[`BIT_MEAS_TIMEOUT] = timeoutFlag;
      fault_flags[`BIT_BAD_SAMPLE] = badSampleFlag;
      fault_flags[`BIT_HEATER_MEAS] = liveFlags[0];
      fault_flags[`BIT_HEATER_CFG] = liveFlags[1];
      fault_flags[`BIT_OUTPUT_CFG] = liveFlags[2];
      fault_flags[`BIT_TEMP_RANGE] = liveFlags[3];
      fault_flags[`BIT_SCALE_ERR] = scaleErr_q;
   end

   // ==========================================
   // Read port
   // Read-only word
   assign addrHit = (readAddr == STATUS_ADDR[ADDR_W-1:0]);

   always @* begin
      if (addrHit) begin
         readData_d = fault_flags;
      end else begin
         readData_d = 16'h0000;
      end
   end

   // No write path, so the word stays read-only
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         readData <= RESET_WORD;
      end else begin
         readData <= readData_d;
      end
   end
endmodule // sensor_fault_status_flags
`default_nettype wire

// file: core/sticky_flag.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sticky flag, set wins over clear
module sticky_flag #(
   parameter RESET_VAL = 1'b0
) (
   input wire ref_clk,
   input wire rst_n,
   input wire setEvt,
   input wire clrEvt,
   output reg flag_q
);
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         flag_q <= RESET_VAL;
      end else if (setEvt) begin
         flag_q <= 1'b1;
      end else if (clrEvt) begin
         flag_q <= 1'b0;
      end
   end
endmodule // sticky_flag
`default_nettype wire

// file: shared/fault_flags_consts.vh
`ifndef FAULT_FLAGS_CONSTS_VH
`define FAULT_FLAGS_CONSTS_VH
// ==========================================
// Register offsets
`define FAULT_FLAGS_ADDR 16'h0000
// ==========================================
// Bit positions
`define BIT_SELF_DIAG 4
`define BIT_NO_MEAS 7
`define BIT_LOW_VREG 8
`define BIT_MEAS_TIMEOUT 9
`define BIT_BAD_SAMPLE 10
`define BIT_HEATER_MEAS 11
`define BIT_HEATER_CFG 12
`define BIT_OUTPUT_CFG 13
`define BIT_TEMP_RANGE 14
`define BIT_SCALE_ERR 15
// ==========================================
// Reset values
`define FAULT_FLAGS_RESET 16'h0080
`endif

// file: tb/fault_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fault_asserts #(parameter ADDR_W = 16) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic measDone,
   input wire logic measOk,
   input wire logic measTimeout,
   input wire logic badSample,
   input wire logic brownoutReset,
   input wire logic resetCmd,
   input wire logic faultClearWrite,
   input wire logic heaterMeasFail,
   input wire logic heaterCfgBad,
   input wire logic outputCfgBad,
   input wire logic heaterTempOutOfRange,
   input wire logic scaleFactorValid,
   input wire logic [ADDR_W-1:0] readAddr,
   input wire logic [15:0] readData,
   input wire logic selfDiagFlag,
   input wire logic [15:0] fault_flags
);
   logic [15:0] f;
   logic [3:0] live;
   assign f = fault_flags;
   assign live = {heaterTempOutOfRange, outputCfgBad, heaterCfgBad, heaterMeasFail};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_diag_cause: assert property (selfDiagFlag == (f[9] | f[10]) && f[4] == selfDiagFlag)
      else $error("diag flag wrong");
   a_timeout_set: assert property (measTimeout |=> f[9]) else $error("timeout flag");
   a_sample_set: assert property (badSample |=> f[10]) else $error("sample flag");
   a_ok_clear: assert property (measDone && measOk && !measTimeout && !badSample |=> !f[9] && !f[10])
      else $error("ok clear");
   a_first_meas: assert property (measDone || !f[7] |=> !f[7]) else $error("first meas");
   a_scale_set: assert property (!scaleFactorValid |=> f[15]) else $error("scale set");
   a_scale_hold: assert property (f[15] && !(resetCmd && scaleFactorValid) |=> f[15])
      else $error("scale hold");
   a_read_word: assert property (1 |=> readData == ($past(readAddr) == 0 ? $past(f) : 16'h0000))
      else $error("read word");
   a_vreg_set: assert property (brownoutReset |=> f[8]) else $error("low supply flag");
   a_vreg_hold: assert property (f[8] && !resetCmd && !faultClearWrite |=> f[8])
      else $error("low supply hold");
   a_live_follow: assert property (1 |=> f[14:11] == $past(live))
      else $error("live flags");
   cover property (measTimeout);
   cover property (badSample);
   cover property (resetCmd && f[15]);
   cover property (brownoutReset);
endmodule // fault_asserts
bind sensor_fault_status_flags fault_asserts #(.ADDR_W(ADDR_W)) u_fault_asserts (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .measDone(measDone),
   .measOk(measOk),
   .measTimeout(measTimeout),
   .badSample(badSample),
   .brownoutReset(brownoutReset),
   .resetCmd(resetCmd),
   .faultClearWrite(faultClearWrite),
   .heaterMeasFail(heaterMeasFail),
   .heaterCfgBad(heaterCfgBad),
   .outputCfgBad(outputCfgBad),
   .heaterTempOutOfRange(heaterTempOutOfRange),
   .scaleFactorValid(scaleFactorValid),
   .readAddr(readAddr),
   .readData(readData),
   .selfDiagFlag(selfDiagFlag),
   .fault_flags(fault_flags)
);
`default_nettype wire

// file: tb/host_poll.sv
`timescale 1ns/1ps
`default_nettype none
module host_poll #(parameter ADDR_W = 16) (
   input wire logic ref_clk,
   input wire logic [15:0] readData,
   output logic [ADDR_W-1:0] readAddr
);
   initial readAddr = '0;
   // Parked on the status word, so idle polls stay meaningful
   task automatic poll(input logic [ADDR_W-1:0] a, output logic [15:0] d);
      @(negedge ref_clk) readAddr = a;
      @(negedge ref_clk) d = readData;
      readAddr = '0;
   endtask
endmodule // host_poll
`default_nettype wire

// file: tb/test_sensor_fault_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin badCount++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module test_sensor_fault_status_flags;
   logic ref_clk = 0, rst_n = 0, sv = 1, selfDiagFlag;
   logic [6:0] ev = '0;
   logic [3:0] lv = '0;
   logic [15:0] rd, f, readAddr, readData;
   int badCount = 0, checksDone = 0, cyc = 0;
   always #12.5 ref_clk = ~ref_clk;
   sensor_fault_status_flags u_sensor_fault_status_flags (.ref_clk(ref_clk), .rst_n(rst_n), .measDone(ev[0]),
      .measOk(ev[1]), .measTimeout(ev[2]), .badSample(ev[3]), .brownoutReset(ev[4]), .resetCmd(ev[5]),
      .faultClearWrite(ev[6]), .heaterMeasFail(lv[0]), .heaterCfgBad(lv[1]), .outputCfgBad(lv[2]),
      .heaterTempOutOfRange(lv[3]), .scaleFactorValid(sv), .readAddr(readAddr), .readData(readData),
      .selfDiagFlag(selfDiagFlag), .fault_flags(f));
   host_poll u_host_poll (.ref_clk(ref_clk), .readData(readData), .readAddr(readAddr));
   task pulse(input logic [6:0] v);
      @(negedge ref_clk) ev = v;
      @(negedge ref_clk) ev = '0;
   endtask
   task tallyAndFinish;
      $display("checks %0d errors %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         badCount++;
         tallyAndFinish;
      end
   end
   initial begin
      repeat (5) @(negedge ref_clk);
      rst_n = 1;
      u_host_poll.poll(16'h0000, rd);
      `CHK(rd, 16'h0080)
      u_host_poll.poll(16'h0001, rd);
      `CHK(rd, 16'h0000)
      pulse(7'h03);
      `CHK(f, 16'h0000)
      pulse(7'h04);
      `CHK(selfDiagFlag, 1'b1)
      pulse(7'h08);
      `CHK(f, 16'h0610)
      // A failed measurement must not clear the causes
      pulse(7'h01);
      `CHK(f, 16'h0610)
      pulse(7'h03);
      `CHK(f, 16'h0000)
      // Set wins when a timeout meets a good finish
      pulse(7'h07);
      `CHK(f, 16'h0210)
      pulse(7'h03);
      `CHK(selfDiagFlag, 1'b0)
      pulse(7'h10);
      pulse(7'h03);
      `CHK(f, 16'h0100)
      pulse(7'h40);
      `CHK(f, 16'h0000)
      pulse(7'h10);
      pulse(7'h20);
      `CHK(f, 16'h0000)
      for (int i = 0; i < 4; i++) begin
         lv = 4'h1 << i;
         @(negedge ref_clk);
         `CHK(f, 16'h0800 << i)
      end
      lv = '0;
      @(negedge ref_clk);
      `CHK(f, 16'h0000)
      sv = 0;
      @(negedge ref_clk);
      // Reset command with the fix in the same cycle is too early
      sv = 1;
      ev = 7'h20;
      @(negedge ref_clk);
      ev = '0;
      `CHK(f, 16'h8000)
      pulse(7'h20);
      `CHK(f, 16'h0000)
      // Mid-run power cycle clears the low supply and timeout bits and sets no-measurement
      pulse(7'h14);
      `CHK(f, 16'h0310)
      rst_n = 0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1;
      `CHK(f, 16'h0080)
      u_host_poll.poll(16'h0000, rd);
      `CHK(rd, 16'h0080)
      pulse(7'h03);
      `CHK(f, 16'h0000)
      tallyAndFinish;
   end
endmodule // test_sensor_fault_status_flags
`default_nettype wire
